// *** hdl/fsl_pkg.sv ***
// shared constants for the floppy status logic and its host end
package fsl_pkg;
   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_HZ        = 20_000_000;
   localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
   localparam int WG_FM_NS      = 4000;  // write gate lead and tail, fm
   localparam int WG_MFM_NS     = 2000;  // write gate lead and tail, mfm
   localparam int WG_FM_CYC     = (WG_FM_NS * CLK_PER_US) / 1000;
   localparam int WG_MFM_CYC    = (WG_MFM_NS * CLK_PER_US) / 1000;
   localparam int CELL_FM_NS    = 4000;  // bit cell time
   localparam int CELL_MFM_NS   = 2000;
   localparam int CELL_FM_CYC   = (CELL_FM_NS * CLK_PER_US) / 1000;
   localparam int CELL_MFM_CYC  = (CELL_MFM_NS * CLK_PER_US) / 1000;
   localparam int PW_FM_NS      = 1380;  // write pulse width
   localparam int PW_MFM_NS     = 690;
   localparam int PW_FM_CYC     = (PW_FM_NS * CLK_PER_US) / 1000;
   localparam int PW_MFM_CYC    = (PW_MFM_NS * CLK_PER_US) / 1000;
   localparam int STROBE_NS     = 150;   // least strobe width
   localparam int STROBE_CYC    = (STROBE_NS * CLK_PER_US + 999) / 1000;
   localparam int SPINUP_REVS   = 6;
   localparam int SEARCH_REVS   = 5;
   localparam int MOTOR_OFF_REVS = 9;
   localparam int SECT_BASE     = 128;   // sector size for size code 0

   // ************************************************************
   // device registers and status bits
   // ************************************************************
   localparam logic [1:0] REG_CMD  = 2'h0;  // status on read
   localparam logic [1:0] REG_DATA = 2'h3;
   localparam int ST_MOTOR   = 7;
   localparam int ST_WPROT   = 6;
   localparam int ST_SPIN    = 5;
   localparam int ST_MISSING = 4;
   localparam int ST_CRC     = 3;
   localparam int ST_LOST    = 2;
   localparam int ST_BREQ    = 1;
   localparam int ST_BUSY    = 0;
   localparam logic [3:0] CMD_FORCE  = 4'hD;
   localparam logic [3:0] CMD_WTRACK = 4'hF;
   localparam logic [2:0] CMD_WSECT  = 3'h5;

   // ************************************************************
   // host avalon map
   // ************************************************************
   localparam logic [3:0] AV_XFER   = 4'h0;
   localparam logic [3:0] AV_RESULT = 4'h4;
   localparam int XF_READ    = 10;  // 1 = bus read, 0 = bus write
   localparam int XF_ADDR    = 8;   // two address bits
endpackage

// *** hdl/fsl_link_if.sv ***
// register bus between host processor end and controller end
interface fsl_link_if;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       read_strobe_n;
   logic       write_strobe_n;
   logic       byte_request_line;
   logic       command_done_irq;

   modport dev (input addr, wdata, read_strobe_n, write_strobe_n,
                output rdata, byte_request_line, command_done_irq);
   modport hst (output addr, wdata, read_strobe_n, write_strobe_n,
                input rdata, byte_request_line, command_done_irq);
endinterface

// *** hdl/fsl_strobe_edge.sv ***
// leading and trailing edge finder for an active low strobe
module fsl_strobe_edge (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic ce,
   // strobe
   input  wire logic strobe_n,
   output logic      lead,
   output logic      trail
);
   logic prev_n;

   // previous level, idle high
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         prev_n <= 1'b1;
      end else if (ce) begin
         prev_n <= strobe_n;
      end
   end

   // edges are qualified by ce so a frozen block sees none
   assign lead  = ce & prev_n & ~strobe_n;
   assign trail = ce & ~prev_n & strobe_n;
endmodule

// *** hdl/fsl_device_end.sv ***
// controller end: status register, byte requests and write gate sequencing
// Operation
// - sector length is 128, 256, 512, 1024
// - id-to-data gap counts are exact
// - mfm marks take exactly three sync bytes
// - sectors found by id marks only
// - short gaps of two bytes still work
// - recommended minimum gaps used when formatting
// - bit 7 mirrors motor output
// - bit 6 write protect on writes, cleared
// - bit 5 set after six spin-up revolutions
// - bit 5 gives deleted record type
// - bit 4 sector missing, cleared on update
// - bit 3 crc error, cleared on update
// - bit 2 lost byte, cleared on update
// - bit 2 track zero when positioning
// - bit 1 copies byte request line
// - bit 1 index level when positioning
// - bit 0 busy while command runs
// - read clears at trailing, write at leading
// - write gate leads first pulse
// - write gate trails last pulse
// - status read clears interrupt line
// - data access clears byte request
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
module fsl_device_end import fsl_pkg::*; #(
   parameter int SPIN_REVS = SPINUP_REVS,
   parameter int FIND_REVS = SEARCH_REVS,
   parameter int OFF_REVS  = MOTOR_OFF_REVS
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // host side register bus
   fsl_link_if.dev         link,
   // drive and read channel side
   input  wire logic       mfm_mode,
   input  wire logic       index_pulse,
   input  wire logic       track0,
   input  wire logic       write_protect,
   input  wire logic       id_found,
   input  wire logic       id_crc_err,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_byte,
   input  wire logic       rd_deleted,
   input  wire logic       data_crc_err,
   output logic            motor_on,
   output logic            write_gate,
   output logic            write_data_out
);
   typedef enum logic [2:0] {
      S_IDLE, S_SPIN, S_SEARCH, S_READ, S_WLEAD, S_WBYTE, S_WTAIL
   } fsl_state_e;

   fsl_state_e  state;
   logic [7:0]  cmd;
   logic [7:0]  byte_holding_register;
   logic [7:0]  shreg;
   logic [7:0]  rdata;
   logic [15:0] cnt;
   logic [10:0] bytes;
   logic [3:0]  rev;
   logic [3:0]  idle_revs;
   logic [2:0]  bitn;
   logic        busy, pos_mode, spun, wprot, missing, crc_err, lost, deleted;
   logic        breq, irq, idx_q, idx_seen, irq_on_index;

   // ************************************************************
   // strobe decoding
   // ************************************************************
   logic wr_lead, rd_trail;

   fsl_strobe_edge u_wr_edge (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .ce       (ce),
      .strobe_n (link.write_strobe_n),
      .lead     (wr_lead),
      .trail    ()
   );

   fsl_strobe_edge u_rd_edge (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .ce       (ce),
      .strobe_n (link.read_strobe_n),
      .lead     (),
      .trail    (rd_trail)
   );

   // register accesses; reads act on trailing, writes on leading edge
   wire cmd_wr    = wr_lead & (link.addr == REG_CMD);
   wire data_wr   = wr_lead & (link.addr == REG_DATA);
   wire stat_rd   = rd_trail & (link.addr == REG_CMD);
   wire data_rd   = rd_trail & (link.addr == REG_DATA);
   wire is_force  = link.wdata[7:4] == CMD_FORCE;
   wire force_cmd = cmd_wr & is_force;
   // a new command is ignored while busy, only force can break in
   wire start     = cmd_wr & ~is_force & ~busy;
   wire idx_edge  = index_pulse & ~idx_q;
   wire wtrack    = cmd[7:4] == CMD_WTRACK;
   wire is_write  = wtrack | (cmd[7:5] == CMD_WSECT);
   wire last_byte = bytes == 11'h001;
   wire breq_clr  = data_rd | data_wr;

   // ************************************************************
   // density dependent timing
   // ************************************************************
   wire [15:0] wg_cyc   = mfm_mode ? 16'(WG_MFM_CYC) : 16'(WG_FM_CYC);
   wire [15:0] cell_cyc = mfm_mode ? 16'(CELL_MFM_CYC) : 16'(CELL_FM_CYC);
   wire [15:0] pw_cyc   = mfm_mode ? 16'(PW_MFM_CYC) : 16'(PW_FM_CYC);
   wire        cell_end = cnt == cell_cyc - 16'h0001;
   wire        wg_end   = cnt == wg_cyc - 16'h0001;
   // size code in the low command bits picks 128 up to 1024 bytes
   wire [10:0] sect_len = 11'(SECT_BASE) << cmd[1:0];
   // next byte to shift out; an unserviced request writes zeros
   wire [7:0]  next_byte = data_wr ? link.wdata : (breq ? 8'h00 : byte_holding_register);

   // ************************************************************
   // status byte
   // ************************************************************
   wire [7:0] status_byte;
   assign status_byte[ST_MOTOR]   = motor_on;
   assign status_byte[ST_WPROT]   = wprot;
   assign status_byte[ST_SPIN]    = pos_mode ? spun : deleted;
   assign status_byte[ST_MISSING] = missing;
   assign status_byte[ST_CRC]     = crc_err;
   assign status_byte[ST_LOST]    = pos_mode ? track0 : lost;
   assign status_byte[ST_BREQ]    = pos_mode ? index_pulse : breq;
   assign status_byte[ST_BUSY]    = busy;

   assign link.rdata             = rdata;
   assign link.byte_request_line = breq;
   assign link.command_done_irq  = irq;

   // read data follows the address one cycle later
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= (link.addr == REG_CMD) ? status_byte :
                  (link.addr == REG_DATA) ? byte_holding_register : 8'h00;
      end
   end

   // ************************************************************
   // command sequencer; later assignments win, so sets beat clears
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= S_IDLE;
         cmd <= 8'h00;
         byte_holding_register <= 8'h00;
         shreg <= 8'h00;
         cnt <= 16'h0000;
         bytes <= 11'h000;
         {rev, idle_revs, bitn} <= 11'h000;
         {busy, spun, wprot, missing, crc_err, lost, deleted} <= 7'h00;
         {breq, irq, idx_q, idx_seen, irq_on_index} <= 5'h00;
         pos_mode <= 1'b1;
         motor_on <= 1'b0;
         write_gate <= 1'b0;
         write_data_out <= 1'b0;
      end else if (ce) begin
         idx_q <= index_pulse;
         if (breq_clr) breq <= 1'b0;
         if (stat_rd | cmd_wr) irq <= 1'b0;
         if (data_wr) byte_holding_register <= link.wdata;
         if (irq_on_index & idx_edge) irq <= 1'b1;
         // motor drops after some idle revolutions
         if (busy) begin
            idle_revs <= 4'h0;
         end else if (motor_on & idx_edge) begin
            idle_revs <= idle_revs + 4'h1;
            if (idle_revs == 4'(OFF_REVS - 1)) motor_on <= 1'b0;
         end
         if (force_cmd) begin
            state <= S_IDLE;
            busy <= 1'b0;
            write_gate <= 1'b0;
            write_data_out <= 1'b0;
            irq_on_index <= link.wdata[2];
            if (link.wdata[3]) irq <= 1'b1;
            // with no command running the status turns to positioning form
            if (!busy) begin
               {wprot, missing, crc_err, lost, deleted, breq} <= 6'h00;
               pos_mode <= 1'b1;
            end
         end else if (start) begin
            cmd <= link.wdata;
            busy <= 1'b1;
            pos_mode <= ~link.wdata[7];
            {wprot, missing, crc_err, lost, deleted, breq} <= 6'h00;
            irq_on_index <= 1'b0;
            rev <= 4'h0;
            cnt <= 16'h0000;
            motor_on <= 1'b1;
            spun <= motor_on;
            state <= S_SPIN;
         end else begin
            unique case (state)
               S_IDLE: ;
               S_SPIN: begin
                  if (spun) begin
                     rev <= 4'h0;
                     if (pos_mode) begin
                        busy <= 1'b0;
                        irq <= 1'b1;
                        state <= S_IDLE;
                     end else if (is_write & write_protect) begin
                        wprot <= 1'b1;
                        busy <= 1'b0;
                        irq <= 1'b1;
                        state <= S_IDLE;
                     end else begin
                        state <= S_SEARCH;
                     end
                  end else if (idx_edge) begin
                     rev <= rev + 4'h1;
                     if (rev == 4'(SPIN_REVS - 1)) spun <= 1'b1;
                  end
               end
               S_SEARCH: begin
                  // only id marks locate a sector; index counts turns, or starts a write track
                  if (wtrack ? idx_edge : (id_found & ~id_crc_err)) begin
                     cnt <= 16'h0000;
                     bytes <= sect_len;
                     if (is_write) begin
                        write_gate <= 1'b1;
                        breq <= 1'b1;
                        state <= S_WLEAD;
                     end else begin
                        state <= S_READ;
                     end
                  end else begin
                     if (id_found & id_crc_err) crc_err <= 1'b1;
                     if (idx_edge) begin
                        rev <= rev + 4'h1;
                        if (rev == 4'(FIND_REVS - 1)) begin
                           missing <= 1'b1;
                           busy <= 1'b0;
                           irq <= 1'b1;
                           state <= S_IDLE;
                        end
                     end
                  end
               end
               S_READ: begin
                  if (rd_valid) begin
                     byte_holding_register <= rd_byte;
                     if (breq & ~data_rd) lost <= 1'b1;
                     breq <= 1'b1;
                     deleted <= rd_deleted;
                     bytes <= bytes - 11'h001;
                     if (last_byte) begin
                        crc_err <= data_crc_err;
                        busy <= 1'b0;
                        irq <= 1'b1;
                        state <= S_IDLE;
                     end
                  end
               end
               S_WLEAD: begin
                  cnt <= cnt + 16'h0001;
                  if (wg_end) begin
                     shreg <= next_byte;
                     if (breq & ~data_wr) lost <= 1'b1;
                     breq <= 1'b1;
                     cnt <= 16'h0000;
                     bitn <= 3'h0;
                     idx_seen <= 1'b0;
                     state <= S_WBYTE;
                  end
               end
               S_WBYTE: begin
                  write_data_out <= shreg[7] & (cnt < pw_cyc);
                  if (idx_edge) idx_seen <= 1'b1;
                  cnt <= cnt + 16'h0001;
                  if (cell_end) begin
                     cnt <= 16'h0000;
                     shreg <= {shreg[6:0], 1'b0};
                     bitn <= bitn + 3'h1;
                     if (bitn == 3'h7) begin
                        bytes <= bytes - 11'h001;
                        if (wtrack ? (idx_seen | idx_edge) : last_byte) begin
                           state <= S_WTAIL;
                        end else begin
                           shreg <= next_byte;
                           if (breq & ~data_wr) lost <= 1'b1;
                           breq <= 1'b1;
                        end
                     end
                  end
               end
               S_WTAIL: begin
                  write_data_out <= 1'b0;
                  cnt <= cnt + 16'h0001;
                  if (wg_end) begin
                     write_gate <= 1'b0;
                     busy <= 1'b0;
                     irq <= 1'b1;
                     state <= S_IDLE;
                  end
               end
            endcase
         end
      end
   end
endmodule

// *** hdl/fsl_host_end.sv ***
// host processor end: avalon slave that runs strobe cycles on the link
module fsl_host_end import fsl_pkg::*; (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // controller link
   fsl_link_if.hst          link
);
   typedef enum logic [1:0] {H_IDLE, H_STROBE, H_HOLD, H_ACK} fsl_host_e;

   fsl_host_e  state;
   logic [3:0] cnt;
   logic       is_rd;
   logic [7:0] last_rd;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       rd_n, wr_n;

   assign link.addr           = addr;
   assign link.wdata          = wdata;
   assign link.read_strobe_n  = rd_n;
   assign link.write_strobe_n = wr_n;

   // ************************************************************
   // request decode
   // ************************************************************
   wire req      = (avs_read | avs_write) & avs_waitrequest;
   wire xfer_req = avs_write & (avs_address == AV_XFER);
   wire [31:0] result = {22'h000000, link.command_done_irq,
                         link.byte_request_line, last_rd};
   wire [31:0] rd_mux = (avs_address == AV_RESULT) ? result : 32'h00000000;

   // one cycle waitrequest low per answered request; xfers wait for the strobe
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= H_IDLE;
         cnt <= 4'h0;
         is_rd <= 1'b0;
         last_rd <= 8'h00;
         addr <= 2'h0;
         wdata <= 8'h00;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
      end else if (ce) begin
         unique case (state)
            H_IDLE: begin
               if (req & xfer_req) begin
                  // format byte order and gap counts are software's duty
                  addr <= avs_writedata[XF_ADDR +: 2];
                  wdata <= avs_writedata[7:0];
                  is_rd <= avs_writedata[XF_READ];
                  rd_n <= ~avs_writedata[XF_READ];
                  wr_n <= avs_writedata[XF_READ];
                  cnt <= 4'h0;
                  state <= H_STROBE;
               end else if (req) begin
                  avs_readdata <= avs_read ? rd_mux : 32'h00000000;
                  avs_waitrequest <= 1'b0;
                  state <= H_ACK;
               end
            end
            H_STROBE: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(STROBE_CYC - 1)) begin
                  if (is_rd) last_rd <= link.rdata;
                  rd_n <= 1'b1;
                  wr_n <= 1'b1;
                  state <= H_HOLD;
               end
            end
            H_HOLD: begin
               // address stays one cycle past the strobe for trailing edge use
               avs_waitrequest <= 1'b0;
               state <= H_ACK;
            end
            H_ACK: begin
               avs_readdata <= 32'h00000000;
               avs_waitrequest <= 1'b1;
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule

// *** testbench/fsl_monitor.sv ***
// checker for the link between host end and controller end
module fsl_monitor import fsl_pkg::*; (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rstn,
   // link
   input wire logic [1:0] addr,
   input wire logic       read_strobe_n,
   input wire logic       write_strobe_n,
   input wire logic       byte_request_line,
   input wire logic       command_done_irq,
   // drive side
   input wire logic       mfm_mode,
   input wire logic       write_gate,
   input wire logic       write_data_out
);
   logic [15:0] gate_age;
   logic [15:0] quiet;
   wire  [15:0] wg = mfm_mode ? 16'(WG_MFM_CYC) : 16'(WG_FM_CYC);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ages saturate, so a long gate never wraps into a false fail
   always_ff @(posedge ref_clk) begin
      gate_age <= (!rstn || !write_gate) ? 16'h0000 : gate_age + 16'(gate_age != 16'hFFFF);
      quiet <= (!rstn || write_data_out) ? 16'h0000 : quiet + 16'(quiet != 16'hFFFF);
   end
   // ************************************************************
   // strobe effects and write gate framing
   // ************************************************************
   sequence s_data_wr; $fell(write_strobe_n) && addr == REG_DATA; endsequence
   sequence s_data_rd; $rose(read_strobe_n) && addr == REG_DATA; endsequence
   sequence s_stat_rd; $rose(read_strobe_n) && addr == REG_CMD; endsequence
   AST_DATA_WR_CLEAR: assert property (s_data_wr |=> !byte_request_line)
      else $error("byte request kept after data write");
   AST_DATA_RD_CLEAR: assert property (s_data_rd |=> !byte_request_line)
      else $error("byte request kept after data read");
   AST_RD_NO_EARLY: assert property ($fell(read_strobe_n) && addr == REG_DATA
      && byte_request_line |=> byte_request_line) else $error("request cleared on lead edge");
   AST_STAT_RD_IRQ: assert property (s_stat_rd |=> !command_done_irq)
      else $error("irq kept after status read");
   AST_IRQ_HOLDS: assert property (command_done_irq && read_strobe_n
      && $past(read_strobe_n) && write_strobe_n |=> command_done_irq) else $error("irq lost");
   AST_GATE_LEAD: assert property ($rose(write_data_out) |-> gate_age >= wg - 16'h0001)
      else $error("write pulse too soon after gate");
   AST_GATE_TAIL: assert property ($fell(write_gate) |-> quiet >= wg)
      else $error("gate dropped too soon after pulse");
   AST_PULSE_IN_GATE: assert property (write_data_out |-> write_gate)
      else $error("write pulse outside gate");
   AST_WSTROBE_HELD: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3])
      else $error("write strobe too short");
endmodule

// *** testbench/test_floppy_format_status_logic.sv ***
// self-checking bench: host end and controller end joined by the link
module test_floppy_format_status_logic import fsl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rstn = 0, mfm_mode = 1, index_pulse = 0, track0 = 0, write_protect = 0;
   logic id_found = 0, id_crc_err = 0, rd_valid = 0, rd_deleted = 0, data_crc_err = 0;
   logic [7:0]  rd_byte = 8'h00;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 0, avs_write = 0, avs_waitrequest, gate_seen = 0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic        motor_on, write_gate, write_data_out;
   int          miscompares = 0, n_compared = 0;
   fsl_link_if link();
   // short revolution counts keep the run brief
   fsl_device_end #(.SPIN_REVS(2), .FIND_REVS(2), .OFF_REVS(2)) fsl_device_end_inst (
      .ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .link(link), .mfm_mode(mfm_mode),
      .index_pulse(index_pulse), .track0(track0), .write_protect(write_protect),
      .id_found(id_found), .id_crc_err(id_crc_err), .rd_valid(rd_valid), .rd_byte(rd_byte),
      .rd_deleted(rd_deleted), .data_crc_err(data_crc_err), .motor_on(motor_on),
      .write_gate(write_gate), .write_data_out(write_data_out));
   fsl_host_end fsl_host_end_inst (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link));
   fsl_monitor fsl_monitor_inst (.ref_clk(ref_clk), .rstn(rstn), .addr(link.addr),
      .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
      .byte_request_line(link.byte_request_line), .command_done_irq(link.command_done_irq),
      .mfm_mode(mfm_mode), .write_gate(write_gate), .write_data_out(write_data_out));
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (write_gate === 1'b1) gate_seen <= 1'b1;
   // ************************************************************
   // access tasks
   // ************************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one avalon cycle; held until waitrequest is sampled low
   task automatic av_op(input logic [3:0] a, input logic rd, input logic [31:0] d,
                        output logic [31:0] q);
      int n = 0;
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 100) miscompares++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic link_wr(input logic [1:0] a, input logic [7:0] v);
      logic [31:0] q;
      av_op(AV_XFER, 1'b0, {21'h0, 1'b0, a, v}, q);
   endtask
   task automatic link_rd(input logic [1:0] a, output logic [7:0] v);
      logic [31:0] q;
      av_op(AV_XFER, 1'b0, {21'h0, 1'b1, a, 8'h00}, q);
      av_op(AV_RESULT, 1'b1, 32'h0, q);
      v = q[7:0];
   endtask
   task automatic wait_on(input bit irq);
      int n = 0;
      while ((irq ? link.command_done_irq : link.byte_request_line) !== 1'b1 && n < 60000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 60000) miscompares++;
   endtask
   task automatic pulse_index(input int k);
      repeat (k) begin
         index_pulse <= 1'b1;
         repeat (4) @(posedge ref_clk);
         index_pulse <= 1'b0;
         repeat (20) @(posedge ref_clk);
      end
   endtask
   task automatic id_pulse(input logic e);
      id_found <= 1'b1;
      id_crc_err <= e;
      @(posedge ref_clk);
      id_found <= 1'b0;
      @(posedge ref_clk);
   endtask
   // one byte from the read channel, then a gap of 20 clock cycles
   task automatic feed(input logic [7:0] v, input logic del, input logic crc);
      rd_byte <= v;
      rd_deleted <= del;
      data_crc_err <= crc;
      rd_valid <= 1'b1;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
      repeat (20) @(posedge ref_clk);
   endtask
   task automatic finish_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // the whole sequence takes about 50k cycles, mostly the sector write
   initial begin
      repeat (80000) @(posedge ref_clk);
      miscompares++;
      finish_test;
   end
   initial begin
      logic [31:0] q;
      logic [7:0] st, b;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      track0 <= 1'b1;
      repeat (2) @(posedge ref_clk);
      link_rd(REG_CMD, st);
      check("idle status", st, 8'h04);
      track0 <= 1'b0;
      index_pulse <= 1'b1;
      link_rd(REG_CMD, st);
      check("index status", st, 8'h02);
      index_pulse <= 1'b0;
      link_wr(REG_CMD, 8'h00);
      link_rd(REG_CMD, st);
      check("spin start", st & 8'h81, 8'h81);
      pulse_index(2);
      wait_on(1);
      av_op(AV_RESULT, 1'b1, 32'h0, q);
      check("irq raised", {7'h0, q[9]}, 8'h01);
      link_rd(REG_CMD, st);
      check("spun up", st & 8'hE1, 8'hA0);
      av_op(AV_RESULT, 1'b1, 32'h0, q);
      check("irq after status", {7'h0, q[9]}, 8'h00);
      link_wr(REG_CMD, 8'h80);
      id_pulse(1'b1);
      pulse_index(2);
      wait_on(1);
      link_rd(REG_CMD, st);
      check("sector missing", st & 8'h1D, 8'h18);
      link_wr(REG_CMD, 8'h80);
      id_pulse(1'b0);
      for (int i = 0; i < 128; i++) begin
         feed(8'(i), 1'b1, i == 127);
         wait_on(0);
         if (i == 0) begin
            link_rd(REG_CMD, st);
            check("busy and request", st & 8'h03, 8'h03);
         end
         link_rd(REG_DATA, b);
         check("read byte", b, 8'(i));
         av_op(AV_RESULT, 1'b1, 32'h0, q);
         check("request after read", {7'h0, q[8]}, 8'h00);
      end
      wait_on(1);
      link_rd(REG_CMD, st);
      check("deleted with crc", st & 8'h3D, 8'h28);
      link_wr(REG_CMD, 8'h80);
      id_pulse(1'b0);
      for (int i = 0; i < 128; i++) feed(8'h5A, 1'b0, 1'b0);
      wait_on(1);
      link_rd(REG_CMD, st);
      check("lost bytes", st & 8'h3D, 8'h04);
      link_rd(REG_DATA, b);
      write_protect <= 1'b1;
      link_wr(REG_CMD, 8'hA0);
      id_pulse(1'b0);
      wait_on(1);
      link_rd(REG_CMD, st);
      check("protected", st & 8'h41, 8'h40);
      write_protect <= 1'b0;
      link_wr(REG_CMD, 8'hA0);
      id_pulse(1'b0);
      for (int i = 0; i < 128; i++) begin
         wait_on(0);
         link_wr(REG_DATA, 8'(i) ^ 8'hA5);
      end
      wait_on(1);
      link_rd(REG_CMD, st);
      check("write done", st & 8'h45, 8'h00);
      check("gate seen", {7'h0, gate_seen}, 8'h01);
      link_wr(REG_CMD, 8'hD8);
      av_op(AV_RESULT, 1'b1, 32'h0, q);
      check("force irq and request", {6'h0, q[9:8]}, 8'h02);
      finish_test;
   end
endmodule
